// [rtl/supervisor_pkg.sv]
// Constants for the supply supervisor with watchdog and manual reset.
// Operation
// R1: Hold reset while supply low, then at least 140 ms after recovery.
// R2: Assert reset when watchdog kick input fails to change before timeout.
// R3: Watchdog timeout between 1.12 s and 3.20 s, typical 1.60 s.
// R4: Processor toggles the watchdog kick input faster than the timeout.
// R5: Floating or tri-stated kick input disables watchdog supervision.
// R6: Manual reset input driven low initiates reset.
// R7: Manual reset input defaults high through pull-up; unconnected never resets.
// R8: Active-low push-pull reset output is low during any reset condition.
// R9: Optional active-high reset output is always complement of active-low output.
// R10: Three build variants select manual reset, watchdog, high output.
// R11: Kick level changes and reset release restart the watchdog timer.
// R12: Manual and watchdog resets are stretched by the same minimum timeout.
package supervisor_pkg;
	localparam int unsigned CLK_HZ        = 125000000;
	localparam int unsigned RESET_MS      = 140;
	localparam int unsigned WD_TYP_MS     = 1600;
	localparam int unsigned RESET_CYCLES  = CLK_HZ / 1000 * RESET_MS;
	localparam int unsigned WD_CYCLES     = CLK_HZ / 1000 * WD_TYP_MS;
	localparam int unsigned CNT_W         = 28;
	localparam logic [1:0]  VARIANT_MR_WD = 2'h1;
	localparam logic [1:0]  VARIANT_HI_WD = 2'h2;
	localparam logic [1:0]  VARIANT_HI_MR = 2'h3;
	typedef enum logic [1:0] {
		ST_HOLD    = 2'h0,
		ST_STRETCH = 2'h1,
		ST_RUN     = 2'h3
	} sup_state_e;
endpackage

// [rtl/supervisor_timer.sv]
// Loadable down counter with a one-cycle expiry pulse.
`timescale 1ns/1ps
module supervisor_timer #(
	parameter int unsigned W = 28
) (
	input  wire logic         i_mclk,
	input  wire logic         i_reset,
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_count,
	input  wire logic         i_run,
	output logic              o_expired
);
	logic [W-1:0] cnt_r;
	logic         exp_r;
	wire          at_one = (cnt_r == W'(1));
	always_ff @(posedge i_mclk) begin
		if (i_reset || i_load) begin
			cnt_r <= i_count;
		end else if (i_run && cnt_r != '0) begin
			cnt_r <= cnt_r - W'(1);
		end
	end
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			exp_r <= 1'b0;
		end else begin
			exp_r <= !i_load && i_run && at_one;
		end
	end
	assign o_expired = exp_r;
endmodule // supervisor_timer

// [rtl/supply_supervisor_watchdog_reset.sv]
// Top of the supply supervisor: reset stretching, watchdog and manual reset.
`timescale 1ns/1ps
module supply_supervisor_watchdog_reset #(
	parameter logic [1:0]  VARIANT      = supervisor_pkg::VARIANT_MR_WD,
	parameter int unsigned RESET_CYCLES = supervisor_pkg::RESET_CYCLES,
	parameter int unsigned WD_CYCLES    = supervisor_pkg::WD_CYCLES
) (
	input  wire logic i_mclk,
	input  wire logic i_reset,
	input  wire logic i_supply_good,
	input  wire logic i_manual_reset_input_n,
	input  wire logic i_watchdog_kick_input,
	input  wire logic i_watchdog_kick_oe,
	output logic      o_reset_n,
	output logic      o_reset
);
	localparam int unsigned W = supervisor_pkg::CNT_W;
	// Variant selection of the optional functions.
	wire has_mr = (VARIANT != supervisor_pkg::VARIANT_HI_WD); // R10
	wire has_wd = (VARIANT != supervisor_pkg::VARIANT_HI_MR); // R10
	wire has_hi = (VARIANT != supervisor_pkg::VARIANT_MR_WD); // R10

	supervisor_pkg::sup_state_e state_r;
	supervisor_pkg::sup_state_e state_nxt;
	logic kick_prev_r;
	logic rst_n_r;
	logic rst_r;
	logic wd_expired;
	logic stretch_done;

	// An undriven pin reads as the pull-up level, so a bare pin is harmless.
	wire mr_low   = has_mr && !i_manual_reset_input_n; // R6 R7
	// A kick pin that nobody drives leaves the watchdog idle.
	wire wd_on    = has_wd && i_watchdog_kick_oe; // R5
	wire kick_chg = wd_on && (i_watchdog_kick_input != kick_prev_r); // R11
	wire cause    = !i_supply_good || mr_low; // R1 R6
	wire in_run   = (state_r == supervisor_pkg::ST_RUN);
	wire wd_load  = !in_run || kick_chg || !wd_on; // R11
	wire st_load  = (state_r != supervisor_pkg::ST_STRETCH);

	// Stretch timer, reloaded until the stretch phase begins.
	supervisor_timer #(.W(W)) u_stretch (
		.i_mclk    (i_mclk),
		.i_reset   (i_reset),
		.i_load    (st_load),
		.i_count   (W'(RESET_CYCLES)),
		.i_run     (1'b1),
		.o_expired (stretch_done)
	);

	// Watchdog timer; it restarts whenever reset is in force or the kick moves.
	supervisor_timer #(.W(W)) u_watchdog (
		.i_mclk    (i_mclk),
		.i_reset   (i_reset),
		.i_load    (wd_load),
		.i_count   (W'(WD_CYCLES)),
		.i_run     (wd_on),
		.o_expired (wd_expired) // R3
	);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			supervisor_pkg::ST_HOLD: begin
				if (!cause) begin
					state_nxt = supervisor_pkg::ST_STRETCH; // R1 R12
				end
			end
			supervisor_pkg::ST_STRETCH: begin
				if (cause) begin
					state_nxt = supervisor_pkg::ST_HOLD;
				end else if (stretch_done) begin
					state_nxt = supervisor_pkg::ST_RUN; // R1
				end
			end
			supervisor_pkg::ST_RUN: begin
				if (cause) begin
					state_nxt = supervisor_pkg::ST_HOLD;
				end else if (wd_expired && !kick_chg) begin
					// A watchdog reset needs no hold, so it goes straight to stretching.
					state_nxt = supervisor_pkg::ST_STRETCH; // R2 R12
				end
			end
			default: begin
				state_nxt = supervisor_pkg::ST_HOLD;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			state_r     <= supervisor_pkg::ST_HOLD;
			kick_prev_r <= 1'b0;
			rst_n_r     <= 1'b0;
			// The high output must stay the complement of the low one during reset too.
			rst_r       <= has_hi; // R9
		end else begin
			state_r     <= state_nxt;
			kick_prev_r <= i_watchdog_kick_input;
			rst_n_r     <= (state_nxt == supervisor_pkg::ST_RUN); // R8
			rst_r       <= has_hi && (state_nxt != supervisor_pkg::ST_RUN); // R9
		end
	end

	assign o_reset_n = rst_n_r;
	assign o_reset   = rst_r;
endmodule // supply_supervisor_watchdog_reset

// [tb/kick_partner.sv]
// Processor model that kicks the watchdog.
`timescale 1ns/1ps
module kick_partner (
	input  wire logic i_mclk,
	input  wire logic i_run,
	input  wire logic i_oe,
	output logic      o_kick = 1'b0
);
	int gap = 0;
	// A floating pin toggles every cycle so a stale level cannot pass for a kick.
	always @(negedge i_mclk)
		if (!i_oe || (i_run && gap == 0)) begin
			o_kick <= ~o_kick;
			gap    <= 1 + $urandom % 12;
		end else if (gap > 0) gap <= gap - 1;
endmodule // kick_partner

// [tb/supervisor_props.sv]
// Checker for the supervisor reset outputs.
`timescale 1ns/1ps
module supervisor_props #(
	parameter logic [1:0]  VARIANT      = 2'h1,
	parameter int unsigned RESET_CYCLES = 20,
	parameter int unsigned WD_CYCLES    = 50
) (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_supply_good,
	input wire logic i_manual_reset_input_n,
	input wire logic i_watchdog_kick_input,
	input wire logic i_watchdog_kick_oe,
	input wire logic o_reset_n,
	input wire logic o_reset
);
	int        low_r, ok_r, idle_r;
	logic      kick_r;
	wire logic mr_w  = !i_manual_reset_input_n && VARIANT != 2'h2;
	wire logic bad_w = !i_supply_good || mr_w;
	always_ff @(posedge i_mclk) begin
		kick_r <= i_watchdog_kick_input;
		low_r  <= o_reset_n ? 0 : low_r + 1;
		ok_r   <= (i_reset || bad_w) ? 0 : ok_r + 1;
		idle_r <= (!o_reset_n || !i_watchdog_kick_oe || kick_r != i_watchdog_kick_input) ? 0 : idle_r + 1;
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	a_supply_low: assert property (!i_supply_good |=> !o_reset_n) else $error("no reset");
	a_manual_low: assert property (mr_w |=> !o_reset_n) else $error("no manual reset");
	a_min_stretch: assert property ($rose(o_reset_n) |-> low_r >= RESET_CYCLES) else $error("short");
	a_supply_wait: assert property ($rose(o_reset_n) |-> ok_r >= RESET_CYCLES) else $error("early");
	a_late_release: assert property (!o_reset_n |-> low_r < RESET_CYCLES + 5 || ok_r < RESET_CYCLES + 5) else $error("late");
	a_wd_fires: assert property (o_reset_n && VARIANT != 2'h3 |-> idle_r < WD_CYCLES + 5) else $error("no bite");
	a_wd_quiet: assert property (o_reset_n && !bad_w && idle_r + 4 < WD_CYCLES |=> o_reset_n) else $error("bite");
	a_hi_pair: assert property (o_reset == (VARIANT != 2'h1 && !o_reset_n)) else $error("polarity");
endmodule // supervisor_props
bind supply_supervisor_watchdog_reset supervisor_props #(.VARIANT(VARIANT),
	.RESET_CYCLES(RESET_CYCLES), .WD_CYCLES(WD_CYCLES)) i_supervisor_props (.*);

// [tb/supply_supervisor_watchdog_reset_bench.sv]
// Bench for the three supervisor variants.
`timescale 1ns/1ps
module supply_supervisor_watchdog_reset_bench;
	localparam int         RC = 20;
	localparam int         WC = 50;
	// Step table: reset, supply good, manual high, kicking, pin driven, then expected lows.
	localparam logic [7:0] ST [15] = '{8'ha8, 8'h28, 8'h78, 8'h7f, 8'h7f, 8'h6c, 8'h7f, 8'h67,
		8'h7f, 8'h5a, 8'h7a, 8'h7f, 8'h38, 8'hf8, 8'h7f};
	localparam int         WT [15] = '{20, 5, RC-2, 10, 300, WC+6, RC+12, 200, 3, 3, RC-4, 10, 2, 2, RC+8};
	logic       mclk = 1'b0;
	logic [4:0] ctl = 5'h15;
	logic       kick;
	logic [3:1] rn, rh;
	int         miscompares = 0, num_checks = 0, cycles = 0;
	always #4 mclk = ~mclk;
	kick_partner i_kick_partner (.i_mclk(mclk), .i_run(ctl[1]), .i_oe(ctl[0]), .o_kick(kick));
	for (genvar v = 1; v < 4; v++) begin : g_var
		supply_supervisor_watchdog_reset #(.VARIANT(2'(v)), .RESET_CYCLES(RC), .WD_CYCLES(WC))
			i_supply_supervisor_watchdog_reset (.i_mclk(mclk), .i_reset(ctl[4]),
			.i_supply_good(ctl[3]), .i_manual_reset_input_n(ctl[2]), .i_watchdog_kick_input(kick),
			.i_watchdog_kick_oe(ctl[0]), .o_reset_n(rn[v]), .o_reset(rh[v]));
	end
	task automatic stop_test();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic check_resets(input logic [2:0] exp);
		num_checks++;
		if ({rh, rn} !== {~exp[2:1], 1'b0, exp}) begin
			miscompares++;
			$display("CHECK FAILED t=%0t exp=%h act=%h", $time, {~exp[2:1], 1'b0, exp}, {rh, rn});
		end
	endtask
	always @(posedge mclk) if (++cycles > 2000) begin
		miscompares++;
		stop_test();
	end
	initial begin
		void'($urandom(54));
		for (int i = 0; i < 15; i++) begin
			ctl = ST[i][7:3];
			repeat (WT[i]) @(negedge mclk);
			check_resets(ST[i][2:0]);
		end
		stop_test();
	end
endmodule // supply_supervisor_watchdog_reset_bench
